// *** hdl/display_timing_pkg.sv ***
`default_nettype none
package display_timing_pkg;
   // register map, byte addresses on the register port
   localparam int ADDR_W = 12;
   localparam logic [11:0] MODE_CONTROL_OFFSET = 12'h000;
   localparam logic [11:0] CLOCK_DIVIDER_OFFSET = 12'h004;
   localparam logic [11:0] PANEL_SIZE_OFFSET = 12'h008;
   localparam logic [11:0] LINE_TIMING_OFFSET = 12'h00C;
   localparam logic [11:0] FRAME_TIMING_OFFSET = 12'h010;
   localparam logic [11:0] SYNC_POLARITY_OFFSET = 12'h014;
   localparam logic [11:0] RASTER_STATUS_OFFSET = 12'h018;
   localparam logic [11:0] TEST_BAR_BASE = 12'h020;
   localparam logic [11:0] BACKDROP_OFFSET = 12'h040;
   localparam logic [11:0] LAYER_BASE = 12'h100;
   localparam logic [11:0] LAYER_END = 12'h300;
   localparam logic [11:0] WORD_STRIDE = 12'h004;

   // mode control fields
   localparam int MODE_POS = 0;
   localparam int MODE_W = 2;
   localparam int RASTER_EN_POS = 4;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_NORMAL = 2'h1;
   localparam logic [1:0] MODE_COLOR_BAR = 2'h3;

   // divider, size and timing fields
   localparam int DIV_W = 8;
   localparam int DELTA_X_POS = 0;
   localparam int DELTA_X_W = 7;
   localparam int DELTA_Y_POS = 16;
   localparam int DELTA_Y_W = 11;
   localparam int WIDTH_UNIT_SHIFT = 4;
   localparam int FRONT_POS = 0;
   localparam int BACK_POS = 10;
   localparam int PULSE_POS = 20;
   localparam int TIMING_W = 10;
   localparam int HCNT_W = 13;
   localparam int VCNT_W = 12;

   // polarity bits: 1 inverts the output
   localparam int POL_PCLK_POS = 0;
   localparam int POL_HSYNC_POS = 1;
   localparam int POL_VSYNC_POS = 2;
   localparam int POL_DE_POS = 3;
   localparam int POL_W = 4;

   // colour layout, rgb888
   localparam int BLUE_POS = 0;
   localparam int GREEN_POS = 8;
   localparam int RED_POS = 16;
   localparam int COLOR_W = 24;
   localparam int BAR_COUNT = 8;
   localparam int BAR_IDX_W = 3;

   // layer descriptors
   localparam int LAYER_COUNT = 16;
   localparam int LAYER_WORDS = 7;
   localparam int LAYER_IDX_POS = 5;
   localparam int LAYER_WORD_POS = 2;
   localparam int DESC_SIZE = 0;
   localparam int DESC_POS = 1;
   localparam int DESC_ADDR = 2;
   localparam int DESC_CTRL = 3;
   localparam int LAYER_W_POS = 0;
   localparam int LAYER_H_POS = 16;
   localparam int LAYER_X_POS = 0;
   localparam int LAYER_Y_POS = 16;
   localparam int LAYER_DIM_W = 11;
   localparam int LAYER_EN_POS = 31;

   // reset values
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   localparam logic [3:0] POL_RESET = 4'h0;
   localparam logic [23:0] BACKDROP_RESET = 24'h000000;
   // bar 1 black on the left through bar 8 white on the right
   localparam logic [8*24-1:0] BAR_RESET = {24'hFFFFFF, 24'hFFFF00, 24'h00FFFF, 24'h00FF00,
                                            24'hFF00FF, 24'hFF0000, 24'h0000FF, 24'h000000};

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic hsync;
      logic vsync;
      logic de;
      logic [23:0] rgb;
   } raster_t;
endpackage
`default_nettype wire

// *** hdl/tft_panel_timing_generator.sv ***
`default_nettype none
module tft_panel_timing_generator #(
   parameter int LAYER_COUNT = display_timing_pkg::LAYER_COUNT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // register port
   input wire display_timing_pkg::reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   // layer fetch master, read data one cycle after the strobe
   output logic fetch_rd,
   output logic [31:0] fetch_addr,
   input wire logic [31:0] fetch_rdata,
   // panel
   output logic pixel_clk,
   output display_timing_pkg::raster_t panel
);
   localparam int HW = display_timing_pkg::HCNT_W;
   localparam int VW = display_timing_pkg::VCNT_W;
   localparam int TW = display_timing_pkg::TIMING_W;
   localparam int CW = display_timing_pkg::COLOR_W;
   localparam int DW = display_timing_pkg::LAYER_DIM_W;
   localparam int LWORDS = display_timing_pkg::LAYER_WORDS;

   logic [1:0] mode;
   logic raster_en;
   logic [display_timing_pkg::DIV_W-1:0] div_value;
   logic [display_timing_pkg::DELTA_X_W-1:0] delta_x;
   logic [display_timing_pkg::DELTA_Y_W-1:0] delta_y;
   logic [TW-1:0] h_pulse, h_back, h_front, v_pulse, v_back, v_front;
   logic [display_timing_pkg::POL_W-1:0] polarity;
   logic [CW-1:0] bar_color [display_timing_pkg::BAR_COUNT];
   logic [CW-1:0] backdrop_color;
   logic [31:0] layer_desc [LAYER_COUNT][LWORDS];

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= display_timing_pkg::MODE_RESET;
         raster_en <= 1'b0;
         div_value <= display_timing_pkg::DIV_RESET;
         delta_x <= '0;
         delta_y <= '0;
         h_pulse <= '0;
         h_back <= '0;
         h_front <= '0;
         v_pulse <= '0;
         v_back <= '0;
         v_front <= '0;
         polarity <= display_timing_pkg::POL_RESET;
         backdrop_color <= display_timing_pkg::BACKDROP_RESET;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            display_timing_pkg::MODE_CONTROL_OFFSET: begin
               mode <= reg_req.wdata[display_timing_pkg::MODE_POS +: display_timing_pkg::MODE_W];
               raster_en <= reg_req.wdata[display_timing_pkg::RASTER_EN_POS];
            end
            display_timing_pkg::CLOCK_DIVIDER_OFFSET: begin
               div_value <= reg_req.wdata[display_timing_pkg::DIV_W-1:0];
            end
            display_timing_pkg::PANEL_SIZE_OFFSET: begin
               delta_x <= reg_req.wdata[display_timing_pkg::DELTA_X_POS +: display_timing_pkg::DELTA_X_W];
               delta_y <= reg_req.wdata[display_timing_pkg::DELTA_Y_POS +: display_timing_pkg::DELTA_Y_W];
            end
            display_timing_pkg::LINE_TIMING_OFFSET: begin
               h_front <= reg_req.wdata[display_timing_pkg::FRONT_POS +: TW];
               h_back <= reg_req.wdata[display_timing_pkg::BACK_POS +: TW];
               h_pulse <= reg_req.wdata[display_timing_pkg::PULSE_POS +: TW];
            end
            display_timing_pkg::FRAME_TIMING_OFFSET: begin
               v_front <= reg_req.wdata[display_timing_pkg::FRONT_POS +: TW];
               v_back <= reg_req.wdata[display_timing_pkg::BACK_POS +: TW];
               v_pulse <= reg_req.wdata[display_timing_pkg::PULSE_POS +: TW];
            end
            display_timing_pkg::SYNC_POLARITY_OFFSET: begin
               polarity <= reg_req.wdata[display_timing_pkg::POL_W-1:0];
            end
            display_timing_pkg::BACKDROP_OFFSET: begin
               backdrop_color <= reg_req.wdata[CW-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < display_timing_pkg::BAR_COUNT; i++) begin
            bar_color[i] <= display_timing_pkg::BAR_RESET[i*CW +: CW];
         end
      end else if (reg_req.wr) begin
         for (int i = 0; i < display_timing_pkg::BAR_COUNT; i++) begin
            if (reg_req.addr == display_timing_pkg::TEST_BAR_BASE + 12'(i*4)) begin
               bar_color[i] <= reg_req.wdata[CW-1:0];
            end
         end
      end
   end

   // layer descriptor window decode
   logic [11:0] layer_off;
   logic [3:0] layer_sel;
   logic [2:0] word_sel;
   logic layer_hit_addr;

   assign layer_off = reg_req.addr - display_timing_pkg::LAYER_BASE;
   assign layer_sel = layer_off[display_timing_pkg::LAYER_IDX_POS +: 4];
   assign word_sel = layer_off[display_timing_pkg::LAYER_WORD_POS +: 3];
   assign layer_hit_addr = reg_req.addr >= display_timing_pkg::LAYER_BASE
                           && reg_req.addr < display_timing_pkg::LAYER_END
                           && 32'(layer_sel) < 32'(LAYER_COUNT)
                           && 32'(word_sel) < 32'(LWORDS);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int l = 0; l < LAYER_COUNT; l++) begin
            for (int w = 0; w < LWORDS; w++) begin
               layer_desc[l][w] <= display_timing_pkg::WORD_RESET;
            end
         end
      end else if (reg_req.wr && layer_hit_addr) begin
         layer_desc[layer_sel][word_sel] <= reg_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pixel clock divider

   logic [display_timing_pkg::DIV_W-1:0] div_cnt;
   logic [display_timing_pkg::DIV_W-1:0] next_div_cnt;
   logic clock_run;
   logic tick;
   logic raster_run;

   assign clock_run = mode != display_timing_pkg::MODE_OFF;
   // >= guards against the divider shrinking under a running count
   assign tick = clock_run && div_cnt >= div_value;
   assign next_div_cnt = tick ? '0 : div_cnt + 1'b1;
   // only the two documented modes drive the raster
   assign raster_run = raster_en && (mode == display_timing_pkg::MODE_NORMAL
                                     || mode == display_timing_pkg::MODE_COLOR_BAR);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= '0;
      end else if (!clock_run) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // high for the first half of each period; at divide by one it stays high
   // clock polarity, runs ahead of raster enable
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pixel_clk <= 1'b0;
      end else if (!clock_run) begin
         pixel_clk <= polarity[display_timing_pkg::POL_PCLK_POS];
      end else begin
         pixel_clk <= (next_div_cnt <= (div_value >> 1)) ^ polarity[display_timing_pkg::POL_PCLK_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // raster counters

   logic [HW-1:0] hcnt;
   logic [VW-1:0] vcnt;
   logic [HW-1:0] h_act_start, h_act_end, h_total, next_hcnt;
   logic [VW-1:0] v_act_start, v_act_end, v_total;
   logic h_last, v_last;
   logic [7:0] bar_px;
   logic [display_timing_pkg::BAR_IDX_W-1:0] bar_idx;
   logic [7:0] bar_w;

   assign h_act_start = HW'(h_pulse) + HW'(h_back);
   assign h_act_end = h_act_start + HW'({delta_x, 4'h0});
   assign h_total = h_act_end + HW'(h_front);
   assign v_act_start = VW'(v_pulse) + VW'(v_back);
   assign v_act_end = v_act_start + VW'(delta_y);
   assign v_total = v_act_end + VW'(v_front);
   assign h_last = (HW+1)'(hcnt) + 1'b1 >= (HW+1)'(h_total);
   assign v_last = (VW+1)'(vcnt) + 1'b1 >= (VW+1)'(v_total);
   assign next_hcnt = h_last ? '0 : hcnt + 1'b1;
   // eight bars of two sixteenths each
   assign bar_w = {delta_x, 1'b0};

   // counters held at zero while the raster is off
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hcnt <= '0;
         vcnt <= '0;
      end else if (!raster_run) begin
         hcnt <= '0;
         vcnt <= '0;
      end else if (tick) begin
         hcnt <= next_hcnt;
         if (h_last) begin
            vcnt <= v_last ? '0 : vcnt + 1'b1;
         end
      end
   end

   // bar position tracked by counting, no divider needed
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bar_px <= '0;
         bar_idx <= '0;
      end else if (!raster_run) begin
         bar_px <= '0;
         bar_idx <= '0;
      end else if (tick) begin
         if (next_hcnt == h_act_start) begin
            bar_px <= '0;
            bar_idx <= '0;
         end else if (bar_px + 1'b1 >= bar_w) begin
            bar_px <= '0;
            bar_idx <= bar_idx + 1'b1;
         end else begin
            bar_px <= bar_px + 1'b1;
         end
      end
   end

   // position decode
   logic h_sync_on, v_sync_on, h_act, v_act, active;
   logic [DW-1:0] pos_x, pos_y;

   assign h_sync_on = hcnt < HW'(h_pulse);
   assign v_sync_on = vcnt < VW'(v_pulse);
   assign h_act = hcnt >= h_act_start && hcnt < h_act_end;
   assign v_act = vcnt >= v_act_start && vcnt < v_act_end;
   // valid only inside the active window
   assign active = h_act && v_act;
   assign pos_x = DW'(hcnt - h_act_start);
   assign pos_y = DW'(vcnt - v_act_start);

   ////////////////////////////////////////////////////////////////////////////
   // layer lookup

   logic [DW-1:0] lay_w [LAYER_COUNT];
   logic [DW-1:0] lay_h [LAYER_COUNT];
   logic [DW-1:0] lay_x [LAYER_COUNT];
   logic [DW-1:0] lay_y [LAYER_COUNT];
   logic lay_on [LAYER_COUNT];

   for (genvar g = 0; g < LAYER_COUNT; g++) begin : g_layer
      assign lay_w[g] = layer_desc[g][display_timing_pkg::DESC_SIZE][display_timing_pkg::LAYER_W_POS +: DW];
      assign lay_h[g] = layer_desc[g][display_timing_pkg::DESC_SIZE][display_timing_pkg::LAYER_H_POS +: DW];
      assign lay_x[g] = layer_desc[g][display_timing_pkg::DESC_POS][display_timing_pkg::LAYER_X_POS +: DW];
      assign lay_y[g] = layer_desc[g][display_timing_pkg::DESC_POS][display_timing_pkg::LAYER_Y_POS +: DW];
      assign lay_on[g] = layer_desc[g][display_timing_pkg::DESC_CTRL][display_timing_pkg::LAYER_EN_POS]
                         && pos_x >= lay_x[g] && 12'(pos_x) < 12'(lay_x[g]) + 12'(lay_w[g])
                         && pos_y >= lay_y[g] && 12'(pos_y) < 12'(lay_y[g]) + 12'(lay_h[g]);
   end

   logic layer_hit;
   logic [31:0] layer_addr;

   // scan downward so the lowest numbered layer wins
   always_comb begin
      layer_hit = 1'b0;
      layer_addr = '0;
      for (int i = LAYER_COUNT - 1; i >= 0; i--) begin
         if (lay_on[i]) begin
            layer_hit = 1'b1;
            layer_addr = layer_desc[i][display_timing_pkg::DESC_ADDR]
                         + 32'({22'(22'(pos_y - lay_y[i]) * 22'(lay_w[i]))
                                + 22'(pos_x - lay_x[i]), 2'b00});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fetch master and output pipeline

   logic fetch_seen;
   logic [CW-1:0] fetch_word;
   display_timing_pkg::raster_t stage;
   logic stage_layer;
   logic [CW-1:0] fill_color;

   // bar colour in test mode, backdrop in normal mode
   assign fill_color = (mode == display_timing_pkg::MODE_COLOR_BAR) ? bar_color[bar_idx]
                                                                     : backdrop_color;

   // one word per covered pixel, rgb888 in the low bits
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fetch_rd <= 1'b0;
         fetch_addr <= '0;
      end else begin
         fetch_rd <= tick && raster_run && active && layer_hit
                     && mode == display_timing_pkg::MODE_NORMAL;
         if (tick && raster_run && active && layer_hit) begin
            fetch_addr <= layer_addr;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fetch_seen <= 1'b0;
         fetch_word <= '0;
      end else begin
         fetch_seen <= fetch_rd;
         if (fetch_seen) begin
            fetch_word <= fetch_rdata[CW-1:0];
         end
      end
   end

   // first stage holds raw active-high levels of the current position
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage <= '0;
         stage_layer <= 1'b0;
      end else if (!raster_run) begin
         stage <= '0;
         stage_layer <= 1'b0;
      end else if (tick) begin
         stage.hsync <= h_sync_on;
         stage.vsync <= v_sync_on;
         stage.de <= active;
         stage.rgb <= active ? fill_color : '0;
         stage_layer <= active && layer_hit && mode == display_timing_pkg::MODE_NORMAL;
      end
   end

   // outputs trail the counters by two pixels so a fetch can land;
   // a layer word is only in time with a divider of two or more
   // polarity applied last, idle at inactive level
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         panel <= '0;
      end else if (!raster_run) begin
         panel.hsync <= polarity[display_timing_pkg::POL_HSYNC_POS];
         panel.vsync <= polarity[display_timing_pkg::POL_VSYNC_POS];
         panel.de <= polarity[display_timing_pkg::POL_DE_POS];
         panel.rgb <= '0;
      end else if (tick) begin
         panel.hsync <= stage.hsync ^ polarity[display_timing_pkg::POL_HSYNC_POS];
         panel.vsync <= stage.vsync ^ polarity[display_timing_pkg::POL_VSYNC_POS];
         panel.de <= stage.de ^ polarity[display_timing_pkg::POL_DE_POS];
         if (stage_layer) begin
            panel.rgb <= fetch_seen ? fetch_rdata[CW-1:0] : fetch_word;
         end else begin
            panel.rgb <= stage.rgb;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads

   logic [31:0] read_value;

   always_comb begin
      read_value = '0;
      case (reg_req.addr)
         display_timing_pkg::MODE_CONTROL_OFFSET: begin
            read_value[display_timing_pkg::MODE_POS +: display_timing_pkg::MODE_W] = mode;
            read_value[display_timing_pkg::RASTER_EN_POS] = raster_en;
         end
         display_timing_pkg::CLOCK_DIVIDER_OFFSET: begin
            read_value[display_timing_pkg::DIV_W-1:0] = div_value;
         end
         display_timing_pkg::PANEL_SIZE_OFFSET: begin
            read_value[display_timing_pkg::DELTA_X_POS +: display_timing_pkg::DELTA_X_W] = delta_x;
            read_value[display_timing_pkg::DELTA_Y_POS +: display_timing_pkg::DELTA_Y_W] = delta_y;
         end
         display_timing_pkg::LINE_TIMING_OFFSET: begin
            read_value[display_timing_pkg::FRONT_POS +: TW] = h_front;
            read_value[display_timing_pkg::BACK_POS +: TW] = h_back;
            read_value[display_timing_pkg::PULSE_POS +: TW] = h_pulse;
         end
         display_timing_pkg::FRAME_TIMING_OFFSET: begin
            read_value[display_timing_pkg::FRONT_POS +: TW] = v_front;
            read_value[display_timing_pkg::BACK_POS +: TW] = v_back;
            read_value[display_timing_pkg::PULSE_POS +: TW] = v_pulse;
         end
         display_timing_pkg::SYNC_POLARITY_OFFSET: begin
            read_value[display_timing_pkg::POL_W-1:0] = polarity;
         end
         display_timing_pkg::RASTER_STATUS_OFFSET: begin
            read_value[HW-1:0] = hcnt;
            read_value[16 +: VW] = vcnt;
            read_value[30] = active;
            read_value[31] = raster_run;
         end
         display_timing_pkg::BACKDROP_OFFSET: begin
            read_value[CW-1:0] = backdrop_color;
         end
         default: begin
            for (int i = 0; i < display_timing_pkg::BAR_COUNT; i++) begin
               if (reg_req.addr == display_timing_pkg::TEST_BAR_BASE + 12'(i*4)) begin
                  read_value[CW-1:0] = bar_color[i];
               end
            end
            if (layer_hit_addr) begin
               read_value = layer_desc[layer_sel][word_sel];
            end
         end
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_req.rd ? read_value : '0;
      end
   end
endmodule
`default_nettype wire

// *** bench/tft_panel_properties.sv ***
`default_nettype none
module tft_props (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // register port
   input wire display_timing_pkg::reg_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   // panel
   input wire logic pixel_clk,
   input wire display_timing_pkg::raster_t panel
);
   logic [31:0] md, dv, ps, lt, ft, pl;
   logic [15:0] hl, gl, dl, ll, k;
   logic [11:0] vl;
   logic [5:0] q;
   logic hs, vs, de, ok;
   assign hs = panel.hsync ^ pl[1];
   assign vs = panel.vsync ^ pl[2];
   assign de = panel.de ^ pl[3];
   assign k = dv[7:0] + 16'h1;
   // reconfiguring mid-line gives odd lengths, so wait for a quiet setup
   assign ok = q == 6'h3F;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {md, dv, ps, lt, ft, pl} <= '0;
         q <= 6'h00;
      end else begin
         q <= reg_req.wr ? 6'h00 : q + 6'(q != 6'h3F);
         if (reg_req.wr) begin
            case (reg_req.addr)
               12'h000: md <= reg_req.wdata;
               12'h004: dv <= reg_req.wdata;
               12'h008: ps <= reg_req.wdata;
               12'h00C: lt <= reg_req.wdata;
               12'h010: ft <= reg_req.wdata;
               12'h014: pl <= reg_req.wdata;
               default: ;
            endcase
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      hl <= hs ? hl + 16'h1 : 16'h0;
      gl <= hs ? 16'h0 : gl + 16'h1;
      dl <= de ? dl + 16'h1 : 16'h0;
      ll <= $rose(hs) ? 16'h1 : ll + 16'h1;
      vl <= vs ? vl + 12'($rose(hs)) : 12'h0;
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_rd_idle; !$past(reg_req.rd) |-> reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   property p_off; ok && !(md[4] && md[0]) |-> {hs, vs, de} == 3'h0 && panel.rgb == 0;
   endproperty
   a_off: assert property (p_off) else $error("raster active while off");
   property p_de; panel.rgb != 24'h0 |-> de; endproperty
   a_de: assert property (p_de) else $error("pixel data outside valid");
   property p_hs_w; ok && $fell(hs) |-> hl == lt[29:20] * k; endproperty
   a_hs_w: assert property (p_hs_w) else $error("hsync width");
   property p_hbp; ok && $rose(de) |-> gl == lt[19:10] * k; endproperty
   a_hbp: assert property (p_hbp) else $error("line back porch");
   property p_line; ok && $rose(hs) |->
      ll == (lt[29:20] + lt[19:10] + {ps[6:0], 4'h0} + lt[9:0]) * k; endproperty
   a_line: assert property (p_line) else $error("line length");
   property p_de_w; ok && $fell(de) |-> dl == {ps[6:0], 4'h0} * k; endproperty
   a_de_w: assert property (p_de_w) else $error("active width");
   property p_vs_w; ok && $fell(vs) |-> vl == ft[29:20]; endproperty
   a_vs_w: assert property (p_vs_w) else $error("vsync width");
   property p_pclk; ok && md[0] && dv[7:0] == 8'h0 |-> pixel_clk == !pl[0]; endproperty
   a_pclk: assert property (p_pclk) else $error("pixel clock level");
endmodule
bind tft_panel_timing_generator tft_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .pixel_clk(pixel_clk), .panel(panel));
`default_nettype wire

// *** bench/panel_model.sv ***
`default_nettype none
module panel_model (
   // panel pins
   input wire logic clk,
   input wire display_timing_pkg::raster_t panel,
   input wire logic [3:0] pol,
   // frame measurements
   output logic [11:0] lines,
   output logic [11:0] vbp,
   output logic [11:0] vfp,
   output logic [23:0] px [0:127]
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] al, cnt, idle;
   logic [6:0] x;
   logic hs, vs, de, f;
   assign hs = panel.hsync ^ pol[1];
   assign vs = panel.vsync ^ pol[2];
   assign de = panel.de ^ pol[3];
   // sampled on the ref clock, so only right for an undivided pixel clock
   always @(posedge clk) begin
      x <= de ? x + 7'h1 : 7'h0;
      if (de) px[x] <= panel.rgb;
      if ($rose(hs)) cnt <= vs ? 12'h0 : cnt + 12'h1;
      if (de) idle <= 12'h0;
      else if ($rose(hs)) idle <= idle + 12'h1;
      if ($rose(vs)) begin
         lines <= al;
         vfp <= idle;
         al <= 12'h0;
         f <= 1'b0;
      end else if ($rose(de)) begin
         al <= al + 12'h1;
         f <= 1'b1;
         if (!f) vbp <= cnt - 12'h1;
      end
   end
endmodule
`default_nettype wire

// *** bench/tft_panel_timing_generator_tb.sv ***
`default_nettype none
module tft_panel_timing_generator_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, sys_rst, fetch_rd, pixel_clk;
   logic [31:0] reg_rdata, fetch_addr;
   logic [11:0] lines, vbp, vfp;
   logic [23:0] px [0:127];
   display_timing_pkg::reg_req_t rq;
   display_timing_pkg::raster_t panel;
   int num_errors = 0, checked = 0, cyc = 0;
   tft_panel_timing_generator DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(rq),
      .reg_rdata(reg_rdata), .fetch_rd(fetch_rd), .fetch_addr(fetch_addr),
      .fetch_rdata(32'h00AB_CDEF), .pixel_clk(pixel_clk), .panel(panel));
   panel_model PM (.clk(ref_clk), .panel(panel), .pol(4'hF), .lines(lines), .vbp(vbp),
      .vfp(vfp), .px(px));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      rq <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      rq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      rq <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk);
      rq.rd <= 1'b0;
      #1 chk("rdata", reg_rdata, e);
   endtask
   initial begin
      sys_rst = 1'b1;
      rq = '0;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(12'h040, 32'h0);
      rd(12'h020, 32'h0);
      rd(12'h03C, 32'hFFFFFF);
      rd(12'h0FC, 32'h0);
      wr(12'h020, 32'hFF00_8000);
      rd(12'h020, 32'h8000);
      wr(12'h014, 32'hF);
      wr(12'h008, 32'h0003_0001);
      wr(12'h00C, 32'h0020_0C01);
      wr(12'h010, 32'h0020_0402);
      for (int n = 0; n < 8; n++) wr(12'h020 + 12'(n * 4), 32'h8000 >> n);
      // idle with inverted polarity before raster enable
      repeat (80) @(posedge ref_clk);
      wr(12'h000, 32'h13);
      repeat (400) @(posedge ref_clk);
      chk("lines", lines, 32'h3);
      chk("vbp", vbp, 32'h1);
      chk("vfp", vfp, 32'h2);
      for (int i = 0; i < 16; i++) chk("bar", px[i], 32'h8000 >> (i / 2));
      wr(12'h040, 32'h123456);
      wr(12'h000, 32'h11);
      repeat (400) @(posedge ref_clk);
      chk("fill", px[0], 32'h123456);
      chk("fill", px[15], 32'h123456);
      wr(12'h000, 32'h1);
      repeat (80) @(posedge ref_clk);
      wr(12'h004, 32'h1);
      // layer 0 one pixel wide over all lines, fetched word shows at pixel 0
      wr(12'h100, 32'h0003_0001);
      wr(12'h108, 32'h100);
      wr(12'h10C, 32'h8000_0000);
      wr(12'h000, 32'h11);
      repeat (800) @(posedge ref_clk);
      chk("layer", px[0], 32'hABCDEF);
      chk("backdrop", px[2], 32'h123456);
      complete_run();
   end
endmodule
`default_nettype wire
